// [dv/tmr16_pin_model.sv]
// Purpose: Far side driving capture and external count pins
// Assumes: Bench calls its tasks from one process
// Notes:   Pins have no pull, so they are always driven
`timescale 1ns/1ps
`default_nettype none
module tmr16_pin_model (
    input  wire logic clk_i,
    output var logic  ext_count_clock_pin_o,
    output var logic  capture_input_pin_one_o,
    output var logic  capture_input_pin_two_o
);
    // Clocks each pin level is held
    localparam int HOLD = 8;
    initial begin
        ext_count_clock_pin_o = 1'b0;
        capture_input_pin_one_o = 1'b0;
        capture_input_pin_two_o = 1'b0;
    end
    task cap_toggle(input int ch);
        @(posedge clk_i);
        if (ch == 1) begin
            capture_input_pin_one_o <= ~capture_input_pin_one_o;
        end else begin
            capture_input_pin_two_o <= ~capture_input_pin_two_o;
        end
        repeat (HOLD) @(posedge clk_i);
    endtask
    task set_ext(input logic lvl);
        @(posedge clk_i);
        ext_count_clock_pin_o <= lvl;
        repeat (HOLD) @(posedge clk_i);
    endtask
    task ext_pulses(input int n);
        repeat (n) begin
            set_ext(~ext_count_clock_pin_o);
            set_ext(~ext_count_clock_pin_o);
        end
    endtask
endmodule
`default_nettype wire

// [dv/tmr16_timer_assertions.sv]
// Purpose: Port checks for the timer
// Assumes: Bound into every tmr16_timer
// Notes:   Status and irq both lag their flag by one cycle
`timescale 1ns/1ps
`default_nettype none
`include "tmr16_defines.vh"
module tmr16_chk (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       overflow_irq_enable_i,
    input wire logic       capture_irq_enable_i,
    input wire logic       cpu_irq_mask_i,
    input wire logic       halt_i,
    input wire logic       rd_count_low_byte_i,
    input wire logic       wr_count_low_byte_i,
    input wire logic       rd_capture_value_low_one_i,
    input wire logic       wr_capture_value_low_one_i,
    input wire logic       rd_capture_value_low_two_i,
    input wire logic       wr_capture_value_low_two_i,
    input wire logic [7:0] timer_status_o,
    input wire logic       timer_irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Flag views and clearing accesses
    wire logic ovf = timer_status_o[`TMR16_ST_OVF];
    wire logic c1 = timer_status_o[`TMR16_ST_CAP1];
    wire logic c2 = timer_status_o[`TMR16_ST_CAP2];
    wire logic ovf_acc = rd_count_low_byte_i | wr_count_low_byte_i;
    wire logic c1_acc = rd_capture_value_low_one_i | wr_capture_value_low_one_i;
    wire logic c2_acc = rd_capture_value_low_two_i | wr_capture_value_low_two_i;
    // ==========================================================
    // Interrupt line
    property p_irq_mask; cpu_irq_mask_i |=> !timer_irq_o; endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq raised while masked");
    property p_ovf_irq; ovf && $past(overflow_irq_enable_i) && !$past(cpu_irq_mask_i) |-> timer_irq_o; endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");
    property p_cap_irq; (c1 || c2) && $past(capture_irq_enable_i) && !$past(cpu_irq_mask_i) |-> timer_irq_o; endproperty
    a_cap_irq: assert property (p_cap_irq) else $error("capture irq missing");
    property p_irq_cause;
        timer_irq_o |-> (ovf && $past(overflow_irq_enable_i)) || ((c1 || c2) && $past(capture_irq_enable_i));
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without enabled flag");
    // ==========================================================
    // Flag clearing and halt
    property p_ovf_clr; $fell(ovf) |-> $past(ovf_acc, 2) || $past(ovf_acc, 3); endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow cleared without low access");
    property p_c1_clr; $fell(c1) |-> $past(c1_acc, 2) || $past(c1_acc, 3); endproperty
    a_c1_clr: assert property (p_c1_clr) else $error("capture one cleared without low access");
    property p_c2_clr; $fell(c2) |-> $past(c2_acc, 2) || $past(c2_acc, 3); endproperty
    a_c2_clr: assert property (p_c2_clr) else $error("capture two cleared without low access");
    property p_halt; halt_i [*6] |-> !$rose(ovf); endproperty
    a_halt: assert property (p_halt) else $error("overflow while halted");
    c_ovf: cover property ($rose(ovf));
    c_cap: cover property ($rose(c1) || $rose(c2));
    c_irq: cover property ($rose(timer_irq_o));
endmodule
bind tmr16_timer tmr16_chk tmr16_chk_i (.clk_i(clk_i), .rst_i(rst_i), .halt_i(halt_i),
    .overflow_irq_enable_i(overflow_irq_enable_i), .capture_irq_enable_i(capture_irq_enable_i),
    .cpu_irq_mask_i(cpu_irq_mask_i), .rd_count_low_byte_i(rd_count_low_byte_i),
    .wr_count_low_byte_i(wr_count_low_byte_i), .rd_capture_value_low_one_i(rd_capture_value_low_one_i),
    .wr_capture_value_low_one_i(wr_capture_value_low_one_i), .rd_capture_value_low_two_i(rd_capture_value_low_two_i),
    .wr_capture_value_low_two_i(wr_capture_value_low_two_i), .timer_status_o(timer_status_o),
    .timer_irq_o(timer_irq_o));
`default_nettype wire

// [dv/tmr16_timer_bench.sv]
// Purpose: Self-checking bench for the capture timer
// Assumes: Pin model drives the capture and count pins
// Notes:   Counts follow from reload value and divide ratio
`timescale 1ns/1ps
`default_nettype none
`include "tmr16_defines.vh"
module tmr16_timer_bench;
    localparam int RCH = 0, RCL = 1, WCL = 2, RAH = 3, RAL = 4, WAL = 5, SRD = 6;
    localparam int R1H = 7, R1L = 8, W1L = 9, R2H = 10, R2L = 11, W2L = 12, OVF = 5, C1 = 7, C2 = 6;
    logic        clk_i, rst_i, esel, sel1, sel2, oen, cen, one_pulse_select, pwm, mask, halt;
    logic [1:0]  cs;
    logic [12:0] stb;
    wire         ext_pin, cap1_pin, cap2_pin;
    wire         s_rch, s_rcl, s_wcl, s_rah, s_ral, s_wal, s_srd, s_r1h, s_r1l, s_w1l, s_r2h, s_r2l, s_w2l;
    // Strobe vector split into one net per access
    assign {s_w2l, s_r2l, s_r2h, s_w1l, s_r1l, s_r1h, s_srd, s_wal, s_ral, s_rah, s_wcl, s_rcl, s_rch} = stb;
    logic [7:0]  rd, status, d, la, lb, h1, l1, h2, l2;
    logic        irq;
    int          fail_count = 0, tests_run = 0, cyc = 0, t_stb, n, ta, tb, k;
    tmr16_timer tmr16_timer_i (.clk_i(clk_i), .rst_i(rst_i), .clock_select_field_i(cs),
        .ext_clock_edge_select_i(esel), .capture_edge_select_one_i(sel1), .capture_edge_select_two_i(sel2),
        .overflow_irq_enable_i(oen), .capture_irq_enable_i(cen), .one_pulse_select_i(one_pulse_select), .pwm_select_i(pwm),
        .cpu_irq_mask_i(mask), .halt_i(halt), .ext_count_clock_pin_i(ext_pin),
        .capture_input_pin_one_i(cap1_pin), .capture_input_pin_two_i(cap2_pin),
        .rd_count_high_byte_i(s_rch), .rd_count_low_byte_i(s_rcl), .wr_count_low_byte_i(s_wcl),
        .rd_alt_count_high_byte_i(s_rah), .rd_alt_count_low_byte_i(s_ral), .wr_alt_count_low_byte_i(s_wal),
        .rd_timer_status_i(s_srd), .rd_capture_value_high_one_i(s_r1h), .rd_capture_value_low_one_i(s_r1l),
        .wr_capture_value_low_one_i(s_w1l), .rd_capture_value_high_two_i(s_r2h),
        .rd_capture_value_low_two_i(s_r2l), .wr_capture_value_low_two_i(s_w2l),
        .rd_data_o(rd), .timer_status_o(status), .timer_irq_o(irq));
    tmr16_pin_model pins (.clk_i(clk_i), .ext_count_clock_pin_o(ext_pin),
        .capture_input_pin_one_o(cap1_pin), .capture_input_pin_two_o(cap2_pin));
    // ==========================================================
    // Clock, cycle count and hang guard
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    // ==========================================================
    // Access and compare tasks
    task acc(input int s, output logic [7:0] v);
        @(posedge clk_i);
        stb <= 13'h0001 << s;
        t_stb = cyc;
        @(posedge clk_i);
        stb <= 13'h0000;
        #1 v = rd;
    endtask
    task wait_st(input int b);
        n = 0;
        while (status[b] !== 1'b1 && n < 60) begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask
    task chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    task chk_bit(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
            fail_count++;
        end
    endtask
    task give_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    initial begin
        {rst_i, oen, sel1} = 3'h7;
        {esel, sel2, cen, one_pulse_select, pwm, mask, halt} = 7'h00;
        cs = `TMR16_CS_DIV2;
        stb = 13'h0000;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        #1 chk_byte("status after reset", 8'h00, status);
        wait_st(OVF);
        chk_bit("reload wraps soon", 1'b1, n < 20);
        for (k = 0; k < 3; k++) begin
            @(posedge clk_i);
            cs <= (k == 0) ? `TMR16_CS_DIV2 : (k == 1) ? `TMR16_CS_DIV4 : `TMR16_CS_DIV8;
            acc(SRD, d);
            acc(WCL, d);
            ta = t_stb;
            repeat (3) @(posedge clk_i);
            #1 chk_bit("overflow cleared", 1'b0, status[OVF]);
            wait_st(OVF);
            chk_bit("wrap period", 1'b1, cyc - ta >= 3 * (2 << k) && cyc - ta <= 4 * (2 << k) + 6);
        end
        acc(SRD, d);
        acc(RAL, d);
        repeat (3) @(posedge clk_i);
        #1 chk_bit("alt low keeps overflow", 1'b1, status[OVF]);
        acc(RAH, h1);
        acc(RCH, h2);
        chk_byte("alt high", h2, h1);
        acc(SRD, d);
        acc(RCL, d);
        repeat (2) @(posedge clk_i);
        #1 chk_bit("overflow cleared by low read", 1'b0, status[OVF]);
        @(posedge clk_i);
        {oen, mask, cen} <= 3'h3;
        cs <= `TMR16_CS_DIV2;
        acc(RCH, d);
        ta = t_stb;
        acc(RCL, la);
        acc(RCH, d);
        tb = t_stb;
        repeat (40) @(posedge clk_i);
        acc(RCH, d);
        acc(RCL, lb);
        chk_byte("buffered low", la + 8'((tb - ta) / 2), lb);
        acc(RCL, d);
        d = d - la - 8'((t_stb - ta) / 2);
        chk_bit("live low", 1'b1, d <= 8'h01 || d == 8'hFF);
        pins.cap_toggle(1);
        pins.cap_toggle(1);
        repeat (40) @(posedge clk_i);
        pins.cap_toggle(1);
        wait_st(C1);
        chk_bit("capture one flag", 1'b1, status[C1]);
        chk_bit("capture irq masked", 1'b0, irq);
        acc(SRD, d);
        acc(R1H, h1);
        acc(R1L, l1);
        acc(RCH, h2);
        acc(RCL, l2);
        chk_bit("newest capture", 1'b1, 16'({h2, l2} - {h1, l1}) < 16'h0010);
        chk_bit("capture one cleared", 1'b0, status[C1]);
        acc(R1H, d);
        pins.cap_toggle(1);
        pins.cap_toggle(1);
        #1 chk_bit("blocked after high read", 1'b0, status[C1]);
        acc(R1L, d);
        pins.cap_toggle(1);
        pins.cap_toggle(1);
        #1 chk_bit("unblocked after low read", 1'b1, status[C1]);
        @(posedge clk_i);
        mask <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk_bit("capture irq", 1'b1, irq);
        acc(SRD, d);
        acc(W1L, d);
        repeat (2) @(posedge clk_i);
        #1 chk_bit("irq dropped on clear", 1'b0, irq);
        pins.cap_toggle(2);
        #1 chk_bit("channel two ignores rise", 1'b0, status[C2]);
        pins.cap_toggle(2);
        #1 chk_bit("channel two falling", 1'b1, status[C2]);
        acc(SRD, d);
        acc(R2H, h1);
        acc(R2L, l1);
        acc(RCH, h2);
        acc(RCL, l2);
        chk_bit("capture two value", 1'b1, 16'({h2, l2} - {h1, l1}) < 16'h0010);
        for (k = 0; k < 2; k++) begin
            @(posedge clk_i);
            {one_pulse_select, pwm, sel2} <= (k == 0) ? 3'h4 : 3'h3;
            pins.cap_toggle(1);
            pins.cap_toggle(1);
            pins.cap_toggle(2);
            pins.cap_toggle(2);
            #1 chk_bit("channel one off", 1'b0, status[C1]);
            chk_bit("channel two on", 1'b1, status[C2]);
            acc(SRD, d);
            acc(W2L, d);
        end
        for (k = 1; k >= 0; k--) begin
            @(posedge clk_i);
            {one_pulse_select, pwm, esel} <= {2'h0, k[0]};
            cs <= `TMR16_CS_EXT;
            pins.set_ext(~k[0]);
            acc(SRD, d);
            acc(RCL, d);
            acc(WAL, d);
            pins.ext_pulses(3);
            #1 chk_bit("three edges", 1'b0, status[OVF]);
            pins.set_ext(~ext_pin);
            #1 chk_bit("fourth edge wraps", 1'b1, status[OVF]);
        end
        @(posedge clk_i);
        cs <= `TMR16_CS_DIV2;
        acc(SRD, d);
        acc(WCL, d);
        @(posedge clk_i);
        halt <= 1'b1;
        repeat (40) @(posedge clk_i);
        #1 chk_bit("held in halt", 1'b0, status[OVF]);
        @(posedge clk_i);
        halt <= 1'b0;
        wait_st(OVF);
        chk_bit("resumes after halt", 1'b1, n < 14);
        give_verdict();
    end
endmodule
`default_nettype wire

// [rtl/tmr16_defines.vh]
// Purpose: Shared constants for the 16-bit timer with input capture
// Assumes: Included by the prescaler and timer design files
// Notes:   Definitions only
`ifndef TMR16_DEFINES_VH
`define TMR16_DEFINES_VH

// ==========================================================
// Counter values
`define TMR16_RELOAD        16'hFFFC
`define TMR16_MAX           16'hFFFF

// ==========================================================
// Clock select field encodings
`define TMR16_CS_DIV2       2'h0
`define TMR16_CS_DIV4       2'h1
`define TMR16_CS_DIV8       2'h2
`define TMR16_CS_EXT        2'h3

// ==========================================================
// Prescaler terminal counts (divide by 2, 4, 8)
`define TMR16_PRE_W         3
`define TMR16_PRE_TC2       3'h1
`define TMR16_PRE_TC4       3'h3
`define TMR16_PRE_TC8       3'h7

// ==========================================================
// Status register bit positions
`define TMR16_ST_CAP1       7
`define TMR16_ST_CAP2       6
`define TMR16_ST_OVF        5
`define TMR16_ST_W          8

`endif

// [rtl/tmr16_edge_sync.v]
// Purpose: Two-flop synchroniser with selectable edge detector
// Assumes: Input is asynchronous to clk_i
// Notes:   First flop is read only by the second flop
`timescale 1ns/1ps
`default_nettype none
module tmr16_edge_sync (
    input  wire clk_i,
    input  wire rst_i,
    input  wire pin_i,
    input  wire rise_sel_i,
    output wire edge_o
);
    reg sync_a;
    reg sync_b;
    reg sync_c;

    // ==========================================================
    // Synchroniser and history
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= pin_i;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // Pulse on the chosen transition
    assign edge_o = rise_sel_i ? (sync_b & ~sync_c) : (~sync_b & sync_c);
endmodule
`default_nettype wire

// [rtl/tmr16_prescaler.v]
// Purpose: Count tick generator, internal divide or external edge
// Assumes: External edges already synchronised
// Notes:   One-cycle tick output
`timescale 1ns/1ps
`default_nettype none
`include "tmr16_defines.vh"
module tmr16_prescaler (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       run_i,
    input  wire [1:0] clock_select_field_i,
    input  wire       ext_edge_i,
    output reg        tick_o
);
    reg  [`TMR16_PRE_W-1:0] div_cnt;
    reg  [`TMR16_PRE_W-1:0] term;

    // Terminal count from the clock select field
    always @* begin
        case (clock_select_field_i)
            `TMR16_CS_DIV2: term = `TMR16_PRE_TC2;
            `TMR16_CS_DIV4: term = `TMR16_PRE_TC4;
            default:        term = `TMR16_PRE_TC8;
        endcase
    end

    // ==========================================================
    // Divider and tick
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt <= {`TMR16_PRE_W{1'b0}};
            tick_o  <= 1'b0;
        end else if (!run_i) begin
            tick_o  <= 1'b0;
        end else if (clock_select_field_i == `TMR16_CS_EXT) begin
            div_cnt <= {`TMR16_PRE_W{1'b0}};
            tick_o  <= ext_edge_i;
        end else if (div_cnt >= term) begin
            div_cnt <= {`TMR16_PRE_W{1'b0}};
            tick_o  <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
            tick_o  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [rtl/tmr16_timer.v]
// Purpose: 16-bit free-running timer with two input capture channels
// Assumes: Byte access strobes are one-cycle pulses from the CPU side
// Notes:   Output compare, one-pulse and PWM waveforms live elsewhere
//
// Operation
// - Sixteen-bit free-running counter from prescaler
// - Internal rate is clock over 2, 4, 8
// - Alternate copy; its low read keeps overflow
// - Low byte write or reset loads FFFCh
// - High byte read buffers the low byte
// - Buffered low byte frozen until low read
// - Lone low read returns live low byte
// - Wrap from maximum to zero sets overflow
// - Overflow interrupt needs enable and clear mask
// - Overflow clears after status read, low access
// - Runs in wait, holds count in halt
// - Both select bits one count external edges
// - Edge select picks external active transition
// - External edges synchronised, four clocks apart
// - Capture edge copies counter, sets flag
// - Each channel has its own edge select
// - One capture enable, gated by CPU mask
// - Capture flag clears after status, low access
// - High read blocks capture until low read
// - Capture register keeps the newest event
// - One-pulse mode disables first capture channel
// - Capture pins always feed the timer
`timescale 1ns/1ps
`default_nettype none
`include "tmr16_defines.vh"
module tmr16_timer (
    input  wire                    clk_i,
    input  wire                    rst_i,
    // Mode and configuration
    input  wire [1:0]              clock_select_field_i,
    input  wire                    ext_clock_edge_select_i,
    input  wire                    capture_edge_select_one_i,
    input  wire                    capture_edge_select_two_i,
    input  wire                    overflow_irq_enable_i,
    input  wire                    capture_irq_enable_i,
    input  wire                    one_pulse_select_i,
    input  wire                    pwm_select_i,
    input  wire                    cpu_irq_mask_i,
    input  wire                    halt_i,
    // Pins
    input  wire                    ext_count_clock_pin_i,
    input  wire                    capture_input_pin_one_i,
    input  wire                    capture_input_pin_two_i,
    // Byte access strobes
    input  wire                    rd_count_high_byte_i,
    input  wire                    rd_count_low_byte_i,
    input  wire                    wr_count_low_byte_i,
    input  wire                    rd_alt_count_high_byte_i,
    input  wire                    rd_alt_count_low_byte_i,
    input  wire                    wr_alt_count_low_byte_i,
    input  wire                    rd_timer_status_i,
    input  wire                    rd_capture_value_high_one_i,
    input  wire                    rd_capture_value_low_one_i,
    input  wire                    wr_capture_value_low_one_i,
    input  wire                    rd_capture_value_high_two_i,
    input  wire                    rd_capture_value_low_two_i,
    input  wire                    wr_capture_value_low_two_i,
    // Read data, status and interrupt outputs
    output reg  [7:0]              rd_data_o,
    output reg  [`TMR16_ST_W-1:0]  timer_status_o,
    output reg                     timer_irq_o
);
    // ==========================================================
    // State
    reg  [15:0] count;
    reg  [7:0]  low_buffer;
    reg         low_buffered;
    reg         overflow_flag;
    reg         ovf_armed;
    reg  [1:0]  capture_flag;
    reg  [1:0]  cap_armed;
    reg  [1:0]  cap_blocked;
    reg  [15:0] capture_value [0:1];

    wire        tick;
    wire        ext_edge;
    wire [1:0]  cap_edge;
    wire [1:0]  cap_hi_rd;
    wire [1:0]  cap_lo_acc;
    wire [1:0]  cap_lo_rd;
    wire [1:0]  cap_edge_sel;
    wire [1:0]  cap_pin;
    wire        any_low_wr;
    wire        any_high_rd;
    wire        any_low_rd;
    wire        wrap;
    wire        ovf_clear;

    assign cap_hi_rd    = {rd_capture_value_high_two_i, rd_capture_value_high_one_i};
    assign cap_lo_rd    = {rd_capture_value_low_two_i, rd_capture_value_low_one_i};
    assign cap_lo_acc   = cap_lo_rd | {wr_capture_value_low_two_i, wr_capture_value_low_one_i};
    assign cap_edge_sel = {capture_edge_select_two_i, capture_edge_select_one_i};
    assign cap_pin      = {capture_input_pin_two_i, capture_input_pin_one_i};
    assign any_low_wr   = wr_count_low_byte_i | wr_alt_count_low_byte_i;
    assign any_high_rd  = rd_count_high_byte_i | rd_alt_count_high_byte_i;
    assign any_low_rd   = rd_count_low_byte_i | rd_alt_count_low_byte_i;

    // ==========================================================
    // External clock path
    // Synchronised external edge
    tmr16_edge_sync u_ext_sync (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .pin_i      (ext_count_clock_pin_i),
        .rise_sel_i (ext_clock_edge_select_i),
        .edge_o     (ext_edge)
    );

    tmr16_prescaler u_presc (
        .clk_i                (clk_i),
        .rst_i                (rst_i),
        .run_i                (~halt_i),
        .clock_select_field_i (clock_select_field_i),
        .ext_edge_i           (ext_edge),
        .tick_o               (tick)
    );

    // ==========================================================
    // Capture pin synchronisers
    // One detector per channel, always connected
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_cap_sync
            tmr16_edge_sync u_cap_sync (
                .clk_i      (clk_i),
                .rst_i      (rst_i),
                .pin_i      (cap_pin[gi]),
                .rise_sel_i (cap_edge_sel[gi]),
                .edge_o     (cap_edge[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Free-running counter
    assign wrap = tick & (count == `TMR16_MAX);

    always @(posedge clk_i) begin
        if (rst_i) begin
            count <= `TMR16_RELOAD;
        end else if (any_low_wr) begin
            count <= `TMR16_RELOAD;
        end else if (tick) begin
            count <= count + 16'h0001;
        end
    end

    // ==========================================================
    // Counter read buffering
    // Low byte latched by first high read
    always @(posedge clk_i) begin
        if (rst_i) begin
            low_buffer   <= 8'h00;
            low_buffered <= 1'b0;
        end else if (any_low_rd) begin
            low_buffered <= 1'b0;
        end else if (any_high_rd && !low_buffered) begin
            low_buffer   <= count[7:0];
            low_buffered <= 1'b1;
        end
    end

    // ==========================================================
    // Overflow flag
    // Clear only via main low access after armed
    assign ovf_clear = ovf_armed & (rd_count_low_byte_i | wr_count_low_byte_i);

    // Set on wrap; set wins over clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag <= 1'b0;
            ovf_armed     <= 1'b0;
        end else begin
            if (wrap) begin
                overflow_flag <= 1'b1;
            end else if (ovf_clear) begin
                overflow_flag <= 1'b0;
            end
            if (rd_timer_status_i && overflow_flag) begin
                ovf_armed <= 1'b1;
            end else if (ovf_clear || !overflow_flag) begin
                ovf_armed <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Capture channels
    // Per channel
    genvar ci;
    generate
        for (ci = 0; ci < 2; ci = ci + 1) begin : g_cap
            wire enabled;
            wire fire;
            wire clr;
            // First channel idles in one-pulse or PWM mode
            assign enabled = (ci == 1) ? 1'b1 : ~(one_pulse_select_i | pwm_select_i);
            assign fire    = cap_edge[ci] & enabled & ~cap_blocked[ci];
            assign clr     = cap_armed[ci] & cap_lo_acc[ci];
            always @(posedge clk_i) begin
                if (rst_i) begin
                    capture_value[ci] <= 16'h0000;
                    capture_flag[ci]  <= 1'b0;
                    cap_armed[ci]     <= 1'b0;
                    cap_blocked[ci]   <= 1'b0;
                end else begin
                    // Newest event overwrites the register
                    if (fire) begin
                        capture_value[ci] <= count;
                    end
                    if (fire) begin
                        capture_flag[ci] <= 1'b1;
                    end else if (clr) begin
                        capture_flag[ci] <= 1'b0;
                    end
                    if (rd_timer_status_i && capture_flag[ci]) begin
                        cap_armed[ci] <= 1'b1;
                    end else if (clr || !capture_flag[ci]) begin
                        cap_armed[ci] <= 1'b0;
                    end
                    // High read blocks until low read
                    if (cap_lo_rd[ci]) begin
                        cap_blocked[ci] <= 1'b0;
                    end else if (cap_hi_rd[ci]) begin
                        cap_blocked[ci] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Read data mux, registered
    always @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_o <= 8'h00;
        end else if (any_high_rd) begin
            rd_data_o <= count[15:8];
        end else if (any_low_rd) begin
            rd_data_o <= low_buffered ? low_buffer : count[7:0];
        end else if (rd_timer_status_i) begin
            rd_data_o <= {capture_flag[0], capture_flag[1], overflow_flag, 5'h00};
        end else if (rd_capture_value_high_one_i) begin
            rd_data_o <= capture_value[0][15:8];
        end else if (rd_capture_value_low_one_i) begin
            rd_data_o <= capture_value[0][7:0];
        end else if (rd_capture_value_high_two_i) begin
            rd_data_o <= capture_value[1][15:8];
        end else if (rd_capture_value_low_two_i) begin
            rd_data_o <= capture_value[1][7:0];
        end
    end

    // ==========================================================
    // Status and interrupt outputs
    // Status copies pending flags; irq gates them by enables and mask
    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_status_o <= {`TMR16_ST_W{1'b0}};
            timer_irq_o    <= 1'b0;
        end else begin
            timer_status_o                  <= {`TMR16_ST_W{1'b0}};
            timer_status_o[`TMR16_ST_CAP1]  <= capture_flag[0];
            timer_status_o[`TMR16_ST_CAP2]  <= capture_flag[1];
            timer_status_o[`TMR16_ST_OVF]   <= overflow_flag;
            timer_irq_o <= ~cpu_irq_mask_i &
                           ((overflow_irq_enable_i & overflow_flag) |
                            (capture_irq_enable_i & (|capture_flag)));
        end
    end
endmodule
`default_nettype wire
